// ### include/fsa_pkg.sv
// fsa_pkg: constants and types for the sector erase abort sequencer
// assumes an apb slave with 32-bit data and one 50 MHz clock
package fsa_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] FSA_OFS_CLKDIV = 12'h000;
  localparam logic [11:0] FSA_OFS_CMD = 12'h004;
  localparam logic [11:0] FSA_OFS_STAT = 12'h008;
  localparam logic [11:0] FSA_OFS_ERASE = 12'h00C;
  localparam logic [11:0] FSA_ARRAY_BASE = 12'h100;
  localparam logic [11:0] FSA_ARRAY_MASK = 12'hF00;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FSA_BUF_EMPTY_BIT = 7;
  localparam int FSA_DONE_BIT = 6;
  localparam int FSA_ACC_ERR_BIT = 4;
  localparam int FSA_NBLK = 4;
  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] FSA_DIV_RST = 8'h0F;
  localparam logic [7:0] FSA_CMD_RST = 8'h00;
  localparam logic [7:0] FSA_CMD_ABORT = 8'h47;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int FSA_CLK_MHZ = 50;
  localparam int FSA_ABORT_FLASH_TIMING_CLOCK_MAX = 4;
  localparam int FSA_ABORT_BUS_MAX = 5;
  localparam logic [1:0] FSA_ABORT_TICKS = 2'h3;
  localparam logic [15:0] FSA_ERASE_TICKS_DEF = 16'h0FA0;
  // ----------------------------------------------------------------
  // sequence states, gray along the path
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FSA_ST_IDLE = 2'b00,
    FSA_ST_ADDR = 2'b01,
    FSA_ST_CMD = 2'b11,
    FSA_ST_ABORT = 2'b10
  } fsa_seq_e;
  typedef struct packed {
    fsa_seq_e seq;
    logic [1:0] tick_cnt;
    logic [FSA_NBLK-1:0] erasing;
    logic [FSA_NBLK-1:0][15:0] erase_cnt;
    logic buf_empty;
    logic done;
    logic acc_err;
    logic [7:0] cmd;
    logic [7:0] div;
    logic [31:0] prdata;
  } fsa_state_s;
endpackage

// ### tb/fsa_tb.sv
// testbench: self-checking bench for the sector erase abort sequencer
// assumes zero or more apb wait states, one 50 MHz clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fsa_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] blk_rdy;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int num_checks = 0;
  time t_go;
  time t_cap;
  // ----------------------------------------------------------------
  // clock and device
  // ----------------------------------------------------------------
  always #10 clk_in = ~clk_in;
  fsa_sequencer #(.ERASE_TICKS(16'h000C)) i_fsa_sequencer (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .psel_in(psel),
    .penable_in(penable),
    .pwrite_in(pwrite),
    .paddr_in(paddr),
    .pwdata_in(pwdata),
    .prdata_out(prdata),
    .pready_out(pready),
    .pslverr_out(pslverr),
    .block_ready_out(blk_rdy)
  );
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    t_cap = $time;
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      miscompares++;
      wrap_up();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // array write, abort code, launch
  task automatic abort_seq(input logic [11:0] a);
    apb(1'b1, a, 32'h5A5AC3C3);
    apb(1'b1, FSA_OFS_CMD, {24'h000000, FSA_CMD_ABORT});
    apb(1'b1, FSA_OFS_STAT, 32'h00000080);
    t_go = $time;
  endtask
  // poll status until complete, judge the delay
  task automatic wait_done;
    int n;
    int lim;
    n = 0;
    // bound with divider 1, plus capture lag and poll spacing
    lim = (FSA_ABORT_FLASH_TIMING_CLOCK_MAX * 2 + FSA_ABORT_BUS_MAX + 3) * 20;
    do begin
      apb(1'b0, FSA_OFS_STAT, 32'h00000000);
      n++;
    end while (rd[FSA_DONE_BIT] !== 1'b1 && n < 12);
    if (rd[FSA_DONE_BIT] !== 1'b1) begin
      miscompares++;
      wrap_up();
    end else begin
      chk({31'h00000000, (t_cap - t_go) <= lim}, 32'h00000001);
    end
  endtask
  task automatic settle;
    @(posedge clk_in);
    #1;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    apb(1'b0, FSA_OFS_STAT, 32'h00000000);
    chk(rd, 32'h000000C0);
    chk({28'h0000000, blk_rdy}, 32'h0000000F);
    apb(1'b0, 12'h040, 32'h00000000);
    chk({31'h00000000, err}, 32'h00000001);
    apb(1'b1, FSA_OFS_CLKDIV, 32'h00000001);
  endtask
  task automatic t_idle_abort;
    abort_seq(12'h1FC);
    wait_done();
    chk(rd, 32'h000000C0);
  endtask
  task automatic t_cut_two;
    apb(1'b1, FSA_OFS_ERASE, 32'h00000005);
    settle();
    chk({28'h0000000, blk_rdy}, 32'h0000000A);
    abort_seq(12'h100);
    apb(1'b0, FSA_OFS_STAT, 32'h00000000);
    chk(rd, 32'h00000000);
    wait_done();
    chk(rd, 32'h000000D0);
    settle();
    chk({28'h0000000, blk_rdy}, 32'h0000000F);
    apb(1'b0, FSA_OFS_ERASE, 32'h00000000);
    chk(rd, 32'h00000000);
    apb(1'b1, FSA_OFS_STAT, 32'h00000010);
    apb(1'b0, FSA_OFS_STAT, 32'h00000000);
    chk(rd, 32'h000000C0);
    apb(1'b1, FSA_OFS_ERASE, 32'h00000005);
    apb(1'b0, FSA_OFS_ERASE, 32'h00000000);
    chk(rd, 32'h00000005);
    repeat (24) @(posedge clk_in);
    settle();
    chk({28'h0000000, blk_rdy}, 32'h0000000F);
  endtask
  task automatic t_normal_end;
    apb(1'b1, FSA_OFS_ERASE, 32'h00000002);
    repeat (12) @(posedge clk_in);
    abort_seq(12'h180);
    wait_done();
    chk(rd, 32'h000000C0);
    settle();
    chk({28'h0000000, blk_rdy}, 32'h0000000F);
  endtask
  task automatic t_busy_err;
    apb(1'b1, FSA_OFS_ERASE, 32'h00000008);
    abort_seq(12'h104);
    apb(1'b1, FSA_OFS_CMD, {24'h000000, FSA_CMD_ABORT});
    apb(1'b0, FSA_OFS_STAT, 32'h00000000);
    chk(rd, 32'h00000010);
    wait_done();
    chk(rd, 32'h000000D0);
    apb(1'b1, FSA_OFS_STAT, 32'h00000010);
    apb(1'b1, 12'h120, 32'h00000000);
    apb(1'b1, FSA_OFS_CMD, 32'h00000012);
    apb(1'b0, FSA_OFS_STAT, 32'h00000000);
    chk(rd, 32'h000000D0);
    apb(1'b1, FSA_OFS_STAT, 32'h00000010);
    apb(1'b1, FSA_OFS_CMD, {24'h000000, FSA_CMD_ABORT});
    apb(1'b0, FSA_OFS_STAT, 32'h00000000);
    chk(rd, 32'h000000D0);
    apb(1'b1, FSA_OFS_STAT, 32'h00000010);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_idle_abort();
    t_cut_two();
    t_normal_end();
    t_busy_err();
    wrap_up();
  end
endmodule
`default_nettype wire

// ### verilog/fsa_clkdiv.sv
// fsa_clkdiv: makes the flash timing clock as a one-cycle enable
// assumes div_in comes from a register on the same clock
`timescale 1ns/1ps
`default_nettype none
module fsa_clkdiv (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // divider setting, period is div_in plus one cycles
  input wire logic [7:0] div_in,
  // flash timing clock enable
  output logic tick_out
);
  import fsa_pkg::*;

  logic [7:0] cnt;
  logic [7:0] next_cnt;

  // ----------------------------------------------------------------
  // divider counter
  // ----------------------------------------------------------------
  always_comb begin
    if (cnt >= div_in) begin
      next_cnt = 8'h00;
    end else begin
      next_cnt = cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt <= 8'h00;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign tick_out = (cnt >= div_in);
endmodule
`default_nettype wire

// ### verilog/fsa_sequencer.sv
// fsa_sequencer: flash command sequencer for the sector erase abort
// assumes an apb master on clk_in and a host that follows the flow
//
// Notes on behaviour
// [RQ1] any flash array write opens the sequence; code opens it only from idle with the error flag clear
// [RQ2] command code 0x47 selects erase abort
// [RQ3] writing one to buffer-empty flag launches
// [RQ4] cut erase sets error with complete flag
// [RQ5] erase finishing normally leaves error clear
// [RQ6] done within four flash periods plus five
// [RQ7] one abort stops every erasing block
// [RQ8] buffer-empty flag stays clear during abort
// [RQ9] new sequence during abort sets error
// [RQ10] host clears error before next sequence
// [RQ11] host re-erases aborted sector before programming
// [RQ12] block freed for access after abort
// [RQ13] host uses abort only rarely
// [RQ14] abort with no erase completes promptly, clean
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fsa_sequencer #(
  parameter logic [15:0] ERASE_TICKS = fsa_pkg::FSA_ERASE_TICKS_DEF
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // per block array availability
  output logic [fsa_pkg::FSA_NBLK-1:0] block_ready_out
);
  import fsa_pkg::*;

  fsa_state_s st;
  fsa_state_s next_st;
  logic tick;
  logic mapped;
  logic is_array;
  logic wr;
  logic rd_setup;
  logic launch;
  logic err_now;
  logic cut_now;
  logic finish_now;
  logic [31:0] rd_word;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  // ----------------------------------------------------------------
  // flash timing clock
  // ----------------------------------------------------------------
  fsa_clkdiv u_div (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .div_in(st.div),
    .tick_out(tick)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign is_array = ((paddr_in & FSA_ARRAY_MASK) == FSA_ARRAY_BASE);
  assign mapped = is_array || hit(paddr_in, FSA_OFS_CLKDIV) || hit(paddr_in, FSA_OFS_CMD)
    || hit(paddr_in, FSA_OFS_STAT) || hit(paddr_in, FSA_OFS_ERASE);
  assign wr = psel_in && penable_in && pwrite_in && mapped;
  assign rd_setup = psel_in && !penable_in && !pwrite_in;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;
  assign prdata_out = st.prdata;
  assign block_ready_out = ~st.erasing;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit(paddr_in, FSA_OFS_CLKDIV)) begin
      rd_word[7:0] = st.div;
    end else if (hit(paddr_in, FSA_OFS_CMD)) begin
      rd_word[7:0] = st.cmd;
    end else if (hit(paddr_in, FSA_OFS_STAT)) begin
      rd_word[FSA_BUF_EMPTY_BIT] = st.buf_empty;
      rd_word[FSA_DONE_BIT] = st.done;
      rd_word[FSA_ACC_ERR_BIT] = st.acc_err;
    end else if (hit(paddr_in, FSA_OFS_ERASE)) begin
      rd_word[FSA_NBLK-1:0] = st.erasing;
    end
  end

  // ----------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    launch = 1'b0;
    err_now = 1'b0;
    cut_now = 1'b0;
    finish_now = 1'b0;
    if (rd_setup) begin
      next_st.prdata = rd_word;
    end
    // erase timers in every block
    for (int b = 0; b < FSA_NBLK; b++) begin
      if (st.erasing[b] && tick) begin
        if (st.erase_cnt[b] <= 16'h0001) begin
          next_st.erasing[b] = 1'b0;
        end else begin
          next_st.erase_cnt[b] = st.erase_cnt[b] - 16'h0001;
        end
      end
    end
    // error flag clear by writing one
    if (wr && hit(paddr_in, FSA_OFS_STAT) && pwdata_in[FSA_ACC_ERR_BIT]) begin
      next_st.acc_err = 1'b0;
    end
    if (wr && hit(paddr_in, FSA_OFS_CLKDIV)) begin
      next_st.div = pwdata_in[7:0];
    end
    if (wr && hit(paddr_in, FSA_OFS_ERASE) && st.seq != FSA_ST_ABORT) begin
      for (int b = 0; b < FSA_NBLK; b++) begin
        if (pwdata_in[b] && !st.erasing[b]) begin
          next_st.erasing[b] = 1'b1;
          next_st.erase_cnt[b] = ERASE_TICKS;
        end
      end
    end
    case (st.seq)
      FSA_ST_IDLE: begin
        if (wr && is_array && !st.acc_err) begin
          next_st.seq = FSA_ST_ADDR; // RQ1
        end else if (wr && hit(paddr_in, FSA_OFS_CMD)) begin
          err_now = 1'b1;
        end
      end
      FSA_ST_ADDR: begin
        if (wr && hit(paddr_in, FSA_OFS_CMD)) begin
          next_st.cmd = pwdata_in[7:0];
          if (pwdata_in[7:0] == FSA_CMD_ABORT) begin
            next_st.seq = FSA_ST_CMD; // RQ2
          end else begin
            err_now = 1'b1;
            next_st.seq = FSA_ST_IDLE;
          end
        end else if (wr && hit(paddr_in, FSA_OFS_STAT) && pwdata_in[FSA_BUF_EMPTY_BIT]) begin
          err_now = 1'b1;
          next_st.seq = FSA_ST_IDLE;
        end
      end
      FSA_ST_CMD: begin
        if (wr && hit(paddr_in, FSA_OFS_STAT) && pwdata_in[FSA_BUF_EMPTY_BIT] && st.buf_empty) begin
          launch = 1'b1;
          next_st.seq = FSA_ST_ABORT; // RQ3
          next_st.buf_empty = 1'b0; // RQ3
          next_st.done = 1'b0;
          next_st.tick_cnt = 2'h0;
        end else if (wr && (is_array || hit(paddr_in, FSA_OFS_CMD))) begin
          err_now = 1'b1;
          next_st.seq = FSA_ST_IDLE;
        end
      end
      FSA_ST_ABORT: begin
        if (wr && (is_array || hit(paddr_in, FSA_OFS_CMD))) begin
          err_now = 1'b1; // RQ9
        end
        if (next_st.erasing == '0) begin
          finish_now = 1'b1; // RQ5 RQ14
        end else if (tick && st.tick_cnt == FSA_ABORT_TICKS - 2'h1) begin
          finish_now = 1'b1;
          cut_now = 1'b1;
          next_st.erasing = '0; // RQ7 RQ12
        end else if (tick) begin
          next_st.tick_cnt = st.tick_cnt + 2'h1; // RQ6
        end
        if (finish_now) begin
          next_st.seq = FSA_ST_IDLE;
          next_st.done = 1'b1;
          next_st.buf_empty = 1'b1;
        end else begin
          next_st.buf_empty = 1'b0; // RQ8
        end
      end
      default: begin
        next_st.seq = FSA_ST_IDLE;
      end
    endcase
    // set wins over a clear in the same cycle
    if (err_now || cut_now) begin
      next_st.acc_err = 1'b1; // RQ4 RQ9
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st.seq <= FSA_ST_IDLE;
      st.tick_cnt <= 2'h0;
      st.erasing <= '0;
      st.erase_cnt <= '0;
      st.buf_empty <= 1'b1;
      st.done <= 1'b1;
      st.acc_err <= 1'b0;
      st.cmd <= FSA_CMD_RST;
      st.div <= FSA_DIV_RST;
      st.prdata <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [11:0] abort_cycles;
  logic [11:0] abort_limit;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      abort_cycles <= 12'h000;
    end else if (st.seq == FSA_ST_ABORT) begin
      abort_cycles <= abort_cycles + 12'h001;
    end else begin
      abort_cycles <= 12'h000;
    end
  end

  assign abort_limit = 12'(FSA_ABORT_FLASH_TIMING_CLOCK_MAX) * ({4'h0, st.div} + 12'h001) + 12'(FSA_ABORT_BUS_MAX);

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_launch;
    launch;
  endsequence

  sequence s_abort_run;
    (st.seq == FSA_ST_ABORT && !st.buf_empty && !st.done);
  endsequence

  a_seq_open: assert property ( // RQ1
    (st.seq == FSA_ST_IDLE && wr && is_array && !st.acc_err) |=> st.seq == FSA_ST_ADDR)
    else $error("array write did not open sequence");

  a_cmd_decode: assert property ( // RQ2
    (st.seq == FSA_ST_ADDR && wr && hit(paddr_in, FSA_OFS_CMD) && pwdata_in[7:0] == FSA_CMD_ABORT)
    |=> st.seq == FSA_ST_CMD && st.cmd == FSA_CMD_ABORT)
    else $error("abort code not decoded");

  a_launch_start: assert property ( // RQ3
    s_launch |=> s_abort_run)
    else $error("launch did not start abort");

  a_cut_error: assert property ( // RQ4
    cut_now |=> st.done && st.acc_err && st.erasing == '0)
    else $error("cut erase without error flag");

  a_normal_clean: assert property ( // RQ5
    (finish_now && !cut_now && !err_now && !st.acc_err) |=> st.done && !st.acc_err)
    else $error("normal finish raised error");

  a_abort_bound: assert property ( // RQ6
    (st.seq == FSA_ST_ABORT) |-> abort_cycles <= abort_limit)
    else $error("abort exceeded time bound");

  a_all_blocks: assert property ( // RQ7
    ($rose(st.done) && $past(st.seq) == FSA_ST_ABORT) |-> st.erasing == '0 && block_ready_out == '1)
    else $error("block still erasing after abort");

  a_cbe_held: assert property ( // RQ8
    s_launch ##1 (st.seq == FSA_ST_ABORT)[*2] |-> !st.buf_empty && !$past(st.buf_empty))
    else $error("buffer empty set during abort");

  a_busy_error: assert property ( // RQ9
    (st.seq == FSA_ST_ABORT && wr && (is_array || hit(paddr_in, FSA_OFS_CMD))) |=> st.acc_err)
    else $error("new sequence during abort not flagged");

  a_idle_prompt: assert property ( // RQ14
    (launch && st.erasing == '0) |-> ##[1:3] (st.done && st.buf_empty && !st.acc_err))
    else $error("idle abort not completed promptly");
endmodule
`default_nettype wire
